// >>> logic/dmb_mode_burst.sv
// Purpose: mode register store, latency and burst ordering of the memory device
// Assumes: link clock and pins are asynchronous; sampled twice before use
// Notes:   register bus is an AHB-Lite slave with zero wait states
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dmb_mode_burst #(
  parameter int DLL_LOCK = dmb_pkg::DLL_LOCK_NCK  // DLL lock time, link clocks
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [7:0]       haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic      [31:0]      hrdata,
  output logic                  hresp,
  // Link pins
  input  wire logic             link_ck,
  input  wire dmb_pkg::dmb_cmd_s cmd_pins,
  input  wire logic             termination_control_pin,
  // Data pins
  input  wire logic [7:0]       dq_in,
  output logic      [7:0]       dq_out,
  output logic                  dq_oe,
  output logic                  dqs_out,
  output logic                  dqs_oe,
  // Status outputs
  output logic                  dll_reset_pulse,
  output logic                  term_enable,
  output logic                  wr_internal_done
);
  import dmb_pkg::*;

  // ==========================================================
  // Synchronisers
  // ==========================================================
  logic       ck_m, ck_s, ck_d;       // Link clock stages and edge history
  dmb_cmd_s   cmd_m, cmd_s;           // Command pin stages
  logic       odt_m, odt_s;           // Termination pin stages
  logic [7:0] dq_m, dq_s;             // Data pin stages

  // Two flops on every pin, a third on the link clock for edge history; the first stage is never read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_m  <= 1'b0;
      ck_s  <= 1'b0;
      ck_d  <= 1'b0;
      cmd_m <= '{cs_n: 1'b1, default: '0};
      cmd_s <= '{cs_n: 1'b1, default: '0};
      odt_m <= 1'b0;
      odt_s <= 1'b0;
      dq_m  <= 8'h00;
      dq_s  <= 8'h00;
    end else begin
      ck_m  <= link_ck;
      ck_s  <= ck_m;
      ck_d  <= ck_s;
      cmd_m <= cmd_pins;
      cmd_s <= cmd_m;
      odt_m <= termination_control_pin;
      odt_s <= odt_m;
      dq_m  <= dq_in;
      dq_s  <= dq_m;
    end
  end

  logic     ck_rise;  // Link rising edge seen this cycle
  logic     ck_fall;  // Link falling edge seen this cycle
  dmb_cmd_e cmd;      // Command present at this rise
  assign ck_rise = ck_s & ~ck_d;
  assign ck_fall = ~ck_s & ck_d;
  assign cmd     = ck_rise ? dmb_decode(cmd_s) : CMD_DES;

  // ==========================================================
  // Mode register store
  // ==========================================================
  logic [13:0] mr_mem [8];  // One word per mode register location
  logic [2:0]  mr_sel;      // Location addressed by a mode set
  logic        is_mrs;      // Mode set this cycle
  logic [13:0] lbmr;        // Latency and burst mode register
  logic [13:0] mr1;         // Added latency and termination register
  assign mr_sel = {cmd_s.bg[0], cmd_s.ba};
  assign is_mrs = (cmd == CMD_MRS);
  assign lbmr   = mr_mem[SEL_LBMR];
  assign mr1    = mr_mem[SEL_MR1];

  // Whole word replaced; controller is trusted to send every field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 8; i++) begin
        mr_mem[i] <= MR_RESET;
      end
    end else if (is_mrs) begin
      mr_mem[mr_sel] <= cmd_s.addr;
    end else if (lbmr[DLLR_BIT]) begin
      mr_mem[SEL_LBMR][DLLR_BIT] <= 1'b0;
    end
  end

  // DLL reset pulse and lock counter; reset restarts the lock wait
  logic [10:0] lock_cnt;  // Link clocks left until lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dll_reset_pulse <= 1'b0;
      lock_cnt        <= 11'h000;
    end else begin
      dll_reset_pulse <= lbmr[DLLR_BIT] && !is_mrs;
      if (lbmr[DLLR_BIT]) begin
        lock_cnt <= 11'(DLL_LOCK);
      end else if (ck_rise && lock_cnt != 11'h000) begin
        lock_cnt <= lock_cnt - 11'h001;
      end
    end
  end

  // ==========================================================
  // Latency
  // ==========================================================
  logic [5:0] cl;      // Read column latency
  logic [5:0] al;      // Added latency
  logic [5:0] rl;      // Total read latency
  logic [5:0] wl;      // Write latency
  logic [4:0] cwl;     // Write column latency from the bus
  logic [1:0] al_code; // Added latency code
  assign cl      = CL_BASE + 6'({lbmr[CL_HI+2:CL_HI], lbmr[CL_B0]});
  assign al_code = mr1[AL_LO+1:AL_LO];
  // Added latency choices: zero, one less than, two less than column latency
  assign al = (al_code == 2'h1) ? cl - 6'h01 : (al_code == 2'h2) ? cl - 6'h02 : 6'h00;
  assign rl = al + cl;
  assign wl = al + 6'(cwl);

  // ==========================================================
  // Timing watch of the controller
  // ==========================================================
  logic [7:0] since_mrs;  // Link clocks since last mode set, saturating
  logic       rtt_on;     // Nominal termination enabled now
  logic       odt_hit;    // Termination pin high while an affecting mode set lands
  logic       gap_hit;    // Mode set inside cycle time
  logic       upd_hit;    // Other command inside update delay
  assign rtt_on  = mr1[RTT_LO+2:RTT_LO] != 3'h0;
  // pin matters if termination on before or after
  assign odt_hit = is_mrs && odt_s && (mr_sel == SEL_MR1 || mr_sel == SEL_LBMR)
                   && (rtt_on || (mr_sel == SEL_MR1 && cmd_s.addr[RTT_LO+2:RTT_LO] != 3'h0));
  assign gap_hit = is_mrs && since_mrs < MODE_SET_CYCLE_NCK;
  assign upd_hit = (cmd == CMD_RD || cmd == CMD_WR || cmd == CMD_OTHER)
                   && since_mrs < MODE_UPDATE_NCK;

  // Count link clocks after each mode set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_mrs <= 8'hFF;
    end else if (is_mrs) begin
      since_mrs <= 8'h00;
    end else if (ck_rise && since_mrs != 8'hFF) begin
      since_mrs <= since_mrs + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      term_enable <= 1'b0;
    end else begin
      term_enable <= odt_s && rtt_on && since_mrs >= MODE_UPDATE_NCK;
    end
  end

  // ==========================================================
  // Burst engine
  // ==========================================================
  dmb_state_e state;       // Engine state
  logic       b_wr;        // Burst is a write
  logic       b_chop;      // Burst chopped to four
  logic       b_il;        // Interleaved order
  logic       b_fix4;      // Fixed chop write timing
  logic [2:0] b_start;     // Starting column
  logic [2:0] b_beat;      // Beat index
  logic [5:0] b_cnt;       // Latency countdown in link clocks
  logic [2:0] o_col;       // Column of this beat
  logic       o_act;       // Beat is driven or stored
  logic [7:0] burst_mem [8];  // Column data of the open row slice
  logic       edge_now;    // Either link edge
  logic       req_chop;    // Chop wanted by command
  logic       beat_now;    // A beat lands this cycle
  logic [2:0] cur_beat;    // Beat index being transferred
  assign edge_now = ck_rise | ck_fall;
  assign req_chop = (lbmr[BL_LO+1:BL_LO] == BL_FIX4)
                    || (lbmr[BL_LO+1:BL_LO] == BL_OTF && !cmd_s.addr[CHOP_BIT]);

  dmb_beat_order u_order (
    .start_col  (b_start),
    .beat       (cur_beat),
    .interleave (b_il),
    .is_write   (b_wr),
    .chop       (b_chop),
    .col        (o_col),
    .active     (o_act)
  );

  // State, latency count and beat counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= BS_IDLE;
      b_wr    <= 1'b0;
      b_chop  <= 1'b0;
      b_il    <= 1'b0;
      b_fix4  <= 1'b0;
      b_start <= 3'h0;
      b_beat  <= 3'h0;
      b_cnt   <= 6'h00;
    end else begin
      unique case (state)
        BS_IDLE: begin
          if (cmd == CMD_RD || cmd == CMD_WR) begin
            state   <= BS_WAIT;
            b_wr    <= (cmd == CMD_WR);
            b_chop  <= req_chop;
            b_il    <= lbmr[BT_BIT];
            b_fix4  <= lbmr[BL_LO+1:BL_LO] == BL_FIX4;
            b_start <= cmd_s.addr[2:0];
            b_beat  <= 3'h0;
            b_cnt   <= (cmd == CMD_WR) ? wl - 6'h01 : rl - 6'h01;
          end
        end
        BS_WAIT: begin
          if (ck_rise) begin
            if (b_cnt == 6'h00) begin
              state <= BS_BURST;
            end else begin
              b_cnt <= b_cnt - 6'h01;
            end
          end
        end
        BS_BURST: begin
          if (edge_now) begin
            b_beat <= b_beat + 3'h1;
            if (b_beat == FULL_END_BEAT) begin
              state <= BS_IDLE;
            end
          end
        end
        default: state <= BS_IDLE;
      endcase
    end
  end

  // Burst starts on the rise that ends the wait; later beats on each edge
  assign beat_now = (state == BS_WAIT && ck_rise && b_cnt == 6'h00)
                    || (state == BS_BURST && edge_now && b_beat != FULL_END_BEAT);

  // Beat index follows the engine, one ahead of b_beat in the burst; beat 0 shown at wait exit
  assign cur_beat = (state == BS_WAIT) ? 3'h0 : b_beat + 3'h1;

  // Write data capture into the slice memory
  // Beat 0 lands on the rise that ends the wait, so capture follows beat_now
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 8; i++) begin
        burst_mem[i] <= 8'h00;
      end
    end else if (b_wr && o_act && beat_now) begin
      burst_mem[o_col] <= dq_s;
    end
  end

  // Read drive of data and strobe; drivers float outside active beats
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_out  <= 8'h00;
      dq_oe   <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe  <= 1'b0;
    end else if (!b_wr && beat_now) begin
      dq_out  <= burst_mem[o_col];
      dq_oe   <= o_act;
      dqs_out <= ~cur_beat[0];
      dqs_oe  <= o_act;
    end else if (state == BS_IDLE || b_wr) begin
      dq_oe   <= 1'b0;
      dqs_oe  <= 1'b0;
      dqs_out <= 1'b0;
    end
  end

  // Internal write completion; fixed chop ends two link clocks early
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_internal_done <= 1'b0;
    end else begin
      wr_internal_done <= b_wr && state == BS_BURST && edge_now
                          && b_beat == (b_fix4 ? CHOP_PULL_IN_BEAT : FULL_END_BEAT);
    end
  end

  // ==========================================================
  // AHB-Lite slave
  // ==========================================================
  logic       d_wr;      // Write data phase pending
  logic [7:0] d_addr;    // Address of pending write
  logic [2:0] sticky;    // Gap, update and termination flags
  logic       take;      // Address phase taken
  logic [2:0] clr;       // Flags cleared by software
  assign take = hsel && hready && htrans[1];
  assign clr  = (d_wr && d_addr == OFS_STATUS) ? hwdata[2:0] : 3'h0;

  // Address phase capture and read data; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d_wr      <= 1'b0;
      d_addr    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      d_wr   <= take && hwrite && hsize == 3'h2;
      d_addr <= haddr;
      if (take && !hwrite) begin
        unique case (haddr)
          OFS_CTRL:   hrdata <= {27'h0, cwl};
          OFS_STATUS: hrdata <= {26'h0, state != BS_IDLE, lbmr[TM_BIT],
                                 lock_cnt == 11'h000, sticky};
          OFS_LBMR:   hrdata <= {18'h0, lbmr};
          OFS_RDLAT:  hrdata <= {26'h0, rl};
          default:    hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Write column latency control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cwl <= CTRL_RESET;
    end else if (d_wr && d_addr == OFS_CTRL) begin
      cwl <= hwdata[4:0];
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sticky <= 3'h0;
    end else begin
      sticky <= (sticky & ~clr) | {odt_hit, upd_hit, gap_hit};
    end
  end

endmodule : dmb_mode_burst

// >>> logic/dmb_pkg.sv
// Purpose: shared constants and types for the mode register and burst order block
// Assumes: hclk at 20 MHz samples a 400 ns link clock and the command pins
// Notes:   field positions and codes below are used by the main module and the bench
//
// What this block does
// - New mode set replaces stored register value
// - First read beat after total read latency
// - DLL reset bit clears itself automatically
// - Burst type bit picks sequential or interleaved
// - Burst length field: chop, eight, on-the-fly
// - Sequential reads rotate within nibble, then other
// - Interleaved reads use start column XOR beat
// - Chopped reads float drivers for last four slots
// - Writes ascend; chop starts at nibble 0/4
// - Fixed chop writes finish two clocks earlier
// - Bank group and bank select mode register
package dmb_pkg;

  // ==========================================================
  // Clock figures
  // ==========================================================
  localparam int HCLK_NS = 50;   // Own clock period
  localparam int LINK_NS = 400;  // Link clock period used by the bench

  // ==========================================================
  // Register bus map (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Write column latency
  localparam logic [7:0] OFS_STATUS = 8'h04;  // Sticky flags and state
  localparam logic [7:0] OFS_LBMR   = 8'h08;  // Latency and burst mode register copy
  localparam logic [7:0] OFS_RDLAT  = 8'h0C;  // Total read latency in link clocks
  localparam logic [4:0] CTRL_RESET = 5'h09;  // Write column latency after reset

  // Status bit positions
  localparam int ST_GAP  = 0;  // Mode sets too close
  localparam int ST_UPD  = 1;  // Command inside update delay
  localparam int ST_ODT  = 2;  // Termination pin high at affecting mode set
  localparam int ST_LOCK = 3;  // DLL locked
  localparam int ST_TEST = 4;  // Test mode bit set
  localparam int ST_BUSY = 5;  // Burst engine active

  // ==========================================================
  // Mode register fields
  // ==========================================================
  localparam logic [2:0] SEL_LBMR = 3'h0;  // Latency and burst mode register location
  localparam logic [2:0] SEL_MR1  = 3'h1;  // Location holding added latency and termination
  localparam int BL_LO    = 0;   // Burst length field, two bits
  localparam int CL_B0    = 2;   // Read column latency bit 0
  localparam int BT_BIT   = 3;   // Burst type
  localparam int CL_HI    = 4;   // Read column latency bits 3:1 at [6:4]
  localparam int TM_BIT   = 7;   // Test mode
  localparam int DLLR_BIT = 8;   // DLL reset
  localparam int AL_LO    = 3;   // Added latency code in MR1, two bits
  localparam int RTT_LO   = 8;   // Nominal termination code in MR1, three bits
  localparam int CHOP_BIT = 12;  // Burst chop select input on read or write
  localparam logic [1:0] BL_FIX8 = 2'h0;  // Fixed eight beat burst
  localparam logic [1:0] BL_OTF  = 2'h1;  // On the fly
  localparam logic [1:0] BL_FIX4 = 2'h2;  // Fixed four beat chop
  localparam logic [5:0] CL_BASE = 6'h09;  // Read column latency for code zero
  localparam logic [13:0] MR_RESET = 14'h0000;  // Stored value after reset

  // ==========================================================
  // Timing in link clocks
  // ==========================================================
  localparam logic [7:0] MODE_SET_CYCLE_NCK = 8'h08;  // Mode set cycle time
  localparam logic [7:0] MODE_UPDATE_NCK    = 8'h18;  // Mode update delay
  localparam int DLL_LOCK_NCK = 1024;                  // DLL lock time
  localparam logic [2:0] CHOP_PULL_IN_BEAT = 3'h3;     // Last beat of pulled-in write
  localparam logic [2:0] FULL_END_BEAT     = 3'h7;     // Last beat of full burst

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic        cs_n;   // Chip select
    logic        act_n;  // Activate
    logic        ras_n;  // Row strobe
    logic        cas_n;  // Column strobe
    logic        we_n;   // Write enable
    logic        cke;    // Clock enable
    logic [1:0]  bg;     // Bank group
    logic [1:0]  ba;     // Bank address
    logic [13:0] addr;   // Address
  } dmb_cmd_s;

  typedef enum logic [2:0] {
    CMD_DES   = 3'h0,
    CMD_MRS   = 3'h1,
    CMD_RD    = 3'h2,
    CMD_WR    = 3'h3,
    CMD_OTHER = 3'h4
  } dmb_cmd_e;

  typedef enum logic [1:0] {
    BS_IDLE  = 2'h0,
    BS_WAIT  = 2'h1,
    BS_BURST = 2'h2
  } dmb_state_e;

  // Decode the pins seen at a link clock rise
  function automatic dmb_cmd_e dmb_decode(input dmb_cmd_s c);
    if (c.cs_n || !c.cke) return CMD_DES;
    if (!c.act_n) return CMD_OTHER;
    case ({c.ras_n, c.cas_n, c.we_n})
      3'b000:  return CMD_MRS;
      3'b101:  return CMD_RD;
      3'b100:  return CMD_WR;
      3'b111:  return CMD_DES;
      default: return CMD_OTHER;
    endcase
  endfunction : dmb_decode

endpackage : dmb_pkg

// >>> logic/dmb_beat_order.sv
// Purpose: column of each burst beat and whether the beat is driven
// Assumes: inputs are stable registers of the burst engine, except beat, which is decoded from them
// Notes:   purely combinational, one instance in the main module
`timescale 1ns/1ps
module dmb_beat_order (
  // Burst description
  input  wire logic [2:0] start_col,
  input  wire logic [2:0] beat,
  input  wire logic       interleave,
  input  wire logic       is_write,
  input  wire logic       chop,
  // Result
  output logic      [2:0] col,
  output logic            active
);
  import dmb_pkg::*;

  // ==========================================================
  // Column per beat
  // ==========================================================
  always_comb begin
    if (is_write) begin
      col = chop ? {start_col[2], beat[1:0]} : beat;
    end else if (interleave) begin
      col = start_col ^ beat;
    end else begin
      col = {start_col[2] ^ beat[2], 2'(start_col[1:0] + beat[1:0])};
    end
    active = !(chop && beat[2]);
  end

endmodule : dmb_beat_order

// >>> sim/dmb_ctrl_model.sv
// Purpose: controller model on the link pins of the mode and burst block
// Assumes: link clock runs free at 400 ns; command and termination pins change at its falling edge
// Notes:   write data is centred on each link edge of the burst
`timescale 1ns/1ps
module dmb_ctrl_model #(
  parameter int WL = 5  // Write latency in link clocks
) (
  // Link pins
  output logic              link_ck,
  output dmb_pkg::dmb_cmd_s cmd_pins,
  output logic              term_pin,
  output logic [7:0]        dq_in
);
  import dmb_pkg::*;
  realtime t_rise;  // Time of the last command rise
  // ==========================================================
  // Link clock and pins
  // ==========================================================
  always #200 link_ck = ~link_ck;
  initial begin
    link_ck = 1'b0;
    cmd_pins = 24'hFC0000;
    term_pin = 1'b0;
    dq_in = 8'h5A;
  end
  task automatic send(input logic [2:0] rcw, input logic [3:0] loc, input logic [13:0] a);
    @(negedge link_ck);
    cmd_pins = {2'b01, rcw, 1'b1, loc, a};
    @(posedge link_ck);
    t_rise = $realtime;
    @(negedge link_ck);
    // Released pins show the inverse, except cke which stays high
    cmd_pins = ~cmd_pins;
    cmd_pins.cke = 1'b1;
    if (rcw == 3'b100) begin
      #(WL * 400 - 300);
      for (int i = 0; i < 8; i++) begin
        dq_in = 8'hA0 + 8'(i);
        #200;
      end
      dq_in = ~dq_in;
    end
  endtask : send
  task automatic idle;
    repeat (25) @(posedge link_ck);
  endtask : idle
  task automatic set_term(input logic v);
    @(negedge link_ck);
    term_pin = v;
  endtask : set_term
endmodule : dmb_ctrl_model

// >>> sim/dmb_mode_burst_sva.sv
// Purpose: port checks of the mode register and burst block
// Assumes: one domain, hclk, with hresetn as its asynchronous reset
// Notes:   a burst slot is half a link clock, four hclk periods
`timescale 1ns/1ps
module dmb_mode_burst_sva #(
  parameter int DLL_LOCK = dmb_pkg::DLL_LOCK_NCK  // Lock count of the design
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched outputs and termination input
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic termination_control_pin,
  input wire logic dq_oe,
  input wire logic dqs_oe,
  input wire logic dqs_out,
  input wire logic dll_reset_pulse,
  input wire logic term_enable,
  input wire logic wr_internal_done
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rdy; hreadyout && !hresp; endproperty
  a_rdy: assert property (p_rdy) else $error("bus answer not ready okay");
  property p_dll; dll_reset_pulse |=> !dll_reset_pulse; endproperty
  a_dll: assert property (p_dll) else $error("dll pulse too long");
  property p_wr; wr_internal_done |=> !wr_internal_done; endproperty
  a_wr: assert property (p_wr) else $error("write done pulse too long");
  property p_pair; dq_oe == dqs_oe; endproperty
  a_pair: assert property (p_pair) else $error("data and strobe enables differ");
  property p_first; $rose(dq_oe) |-> dqs_out; endproperty
  a_first: assert property (p_first) else $error("first strobe not high");
  property p_len; $rose(dq_oe) |-> dq_oe [*8]; endproperty
  a_len: assert property (p_len) else $error("burst drive too short");
  property p_end; $rose(dq_oe) |-> ##[14:40] !dq_oe; endproperty
  a_end: assert property (p_end) else $error("burst drive too long");
  property p_slot; dq_oe && $changed(dqs_out) |=> $stable(dqs_out) [*2]; endproperty
  a_slot: assert property (p_slot) else $error("beat slot too short");
  property p_term; !termination_control_pin [*4] |=> !term_enable; endproperty
  a_term: assert property (p_term) else $error("termination on with pin low");
endmodule : dmb_mode_burst_sva
bind dmb_mode_burst dmb_mode_burst_sva #(.DLL_LOCK(DLL_LOCK)) u_sva (.hclk, .hresetn,
  .hreadyout, .hresp, .termination_control_pin, .dq_oe, .dqs_oe, .dqs_out,
  .dll_reset_pulse, .term_enable, .wr_internal_done);

// >>> sim/dmb_mode_burst_tb.sv
// Purpose: self checking bench of the mode register and burst block
// Assumes: the model owns the link pins; the bench owns the bus
// Notes:   one full write to column 0 fills the burst memory
`timescale 1ns/1ps
module dmb_mode_burst_tb;
  import dmb_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, link_ck, term_pin;
  logic        dq_oe, dqs_oe, dqs_out, dll_reset_pulse, term_enable, wr_internal_done;
  logic        bt, a12, chop, oe;
  logic [1:0]  htrans, bl;
  logic [2:0]  hsize, s, c;
  logic [7:0]  haddr, dq_in, dq_out;
  logic [31:0] hwdata, hrdata, rd;
  dmb_cmd_s    cmd_pins;
  int          err_total = 0, checks = 0, n_dll = 0, n_wd = 0, n;
  // Rows: burst type, length code, chop select, start column
  logic [6:0]  rows [5] = '{{1'b0, BL_FIX8, 1'b1, 3'h5}, {1'b1, BL_FIX8, 1'b1, 3'h3},
    {1'b0, BL_FIX4, 1'b1, 3'h6}, {1'b1, BL_OTF, 1'b0, 3'h5}, {1'b0, BL_OTF, 1'b1, 3'h7}};
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  // Count DLL reset and write done pulses, they last one cycle only
  always @(posedge hclk) if (dll_reset_pulse === 1'b1) n_dll <= n_dll + 1;
  always @(posedge hclk) if (wr_internal_done === 1'b1) n_wd <= n_wd + 1;
  dmb_mode_burst #(.DLL_LOCK(4)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .link_ck, .cmd_pins,
    .termination_control_pin(term_pin), .dq_in, .dq_out, .dq_oe, .dqs_out, .dqs_oe,
    .dll_reset_pulse, .term_enable, .wr_internal_done);
  dmb_ctrl_model m (.link_ck, .cmd_pins, .term_pin, .dq_in);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  // One single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : ahb
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // A hang is cut short well past the expected run
  initial begin
    #1000000;
    err_total++;
    print_verdict;
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1200;
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'(CTRL_RESET), rd);
    ahb(1'b1, OFS_CTRL, 32'h5);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h5, rd);
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int k = 0; k < 2; k++) begin
      m.send(3'b000, 4'(k), 14'h0000); // locations 0 and 1 fully set
      m.idle();
    end
    m.send(3'b100, 4'h0, 14'h1000); // full write from column 0
    m.idle();
    chk("write done", 32'h1, 32'(n_wd)); // one reference point
    foreach (rows[r]) begin
      {bt, bl, a12, s} = rows[r];
      m.send(3'b000, 4'h0, {10'h0, bt, 1'b0, bl}); // burst mode set
      m.idle();
      ahb(1'b0, OFS_LBMR, 32'h0);
      chk("lbmr", {28'h0, bt, 1'b0, bl}, rd); // stored value replaced
      m.send(3'b101, 4'h0, {1'b0, a12, 9'h0, s});
      chop = (bl == BL_FIX4) || (bl == BL_OTF && !a12);
      n = 0;
      while (dq_oe !== 1'b1 && n < 400) begin
        @(negedge hclk);
        n++;
      end
      chk("latency", 32'h1, 32'(int'($realtime - m.t_rise) inside {[3600:3850]})); // whole clocks
      #100;
      for (int j = 0; j < 8; j++) begin
        c = bt ? s ^ 3'(j) : {s[2] ^ (j > 3), s[1:0] + 2'(j)};
        oe = !(chop && j > 3);
        chk("beat", 32'({oe, oe ? 8'hA0 + 8'(c) : 8'h00}), 32'({dq_oe, oe ? dq_out : 8'h00}));
        #200;
      end
      m.idle();
    end
    $display("test burst order rows done");
    ahb(1'b0, OFS_RDLAT, 32'h0);
    chk("rdlat", 32'h9, rd); // total read latency
    m.send(3'b000, 4'h0, 14'h0100); // lock wait after reset of the loop
    m.idle();
    chk("dll pulse", 32'h1, 32'(n_dll)); // one reset issued
    ahb(1'b0, OFS_LBMR, 32'h0);
    chk("dll clear", 32'h0, rd); // bit back to zero
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h8, rd); // locked, no flags raised
    m.send(3'b000, 4'h1, 14'h0100);
    m.idle();
    ahb(1'b0, OFS_LBMR, 32'h0);
    chk("lbmr kept", 32'h0, rd); // other location written
    m.set_term(1'b1);
    repeat (8) @(negedge hclk);
    chk("term on", 32'h1, 32'(term_enable)); // pin honoured after update
    m.set_term(1'b0);
    repeat (8) @(negedge hclk);
    chk("term off", 32'h0, 32'(term_enable)); // pin low turns it off
    $display("test hand cases done");
    print_verdict;
  end
endmodule : dmb_mode_burst_tb
